// [src/slice_pkg.sv]
// Shared constants for the execution slice: opcode fields, status bit
// positions, reset values and the state encodings of the issue control.
// Assumes a 32-bit core whose decode stage hands over whole instruction words.
package slice_pkg;

	// Instruction field positions.
	localparam int OP_HI = 31;
	localparam int OP_LO = 26;
	localparam int RS_HI = 25;
	localparam int RS_LO = 21;
	localparam int RT_HI = 20;
	localparam int RT_LO = 16;
	localparam int RD_HI = 15;
	localparam int RD_LO = 11;
	localparam int SA_HI = 10;
	localparam int SA_LO = 6;
	localparam int FN_HI = 5;
	localparam int FN_LO = 0;
	localparam int CO_BIT = 25;
	localparam int SC_BIT = 5;

	// Major opcodes and function codes.
	localparam logic [5:0] OPC_SPECIAL = 6'h00;
	localparam logic [5:0] OPC_COP0 = 6'h10;
	localparam logic [5:0] OPC_COP1 = 6'h11;
	localparam logic [5:0] OPC_SPECIAL3 = 6'h1F;
	localparam logic [5:0] FN_DIVIDE_U = 6'h1B;
	localparam logic [5:0] FN_MOVE_REM = 6'h10;
	localparam logic [5:0] FN_MOVE_QUOT = 6'h12;
	localparam logic [5:0] FN_EXC_RETURN = 6'h18;
	localparam logic [5:0] FN_PULL = 6'h00;
	localparam logic [5:0] FN_FP_DIV = 6'h03;
	localparam logic [4:0] RS_MISC_CP0 = 5'h0B;

	// Shift-left-logical of r0 into r0 by three places.
	localparam logic [31:0] BARRIER_WORD = 32'h000000C0;

	// Status register bits and reset value.
	localparam int SB_IE = 0;
	localparam int SB_EXL = 1;
	localparam int SB_ERL = 2;
	localparam int SB_BEV = 22;
	localparam logic [31:0] STATUS_RST = 32'h00400004;

	localparam logic [2:0] REV_TWO = 3'h2;
	localparam logic [5:0] DIV_STEPS = 6'h20;

	// Issue control states.
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_DIVW = 3'b100
	} state_t;

	// Operation parked while the divider is busy.
	typedef enum logic [1:0] {
		PEND_NONE = 2'h0,
		PEND_REM = 2'h1,
		PEND_QUOT = 2'h2,
		PEND_DIV = 2'h3
	} pend_t;

endpackage

// [src/div_if.sv]
// Link between the issue control and the unsigned divide engine.
// Assumes both ends share sys_clk; start is a single-cycle request.
`timescale 1ns/100ps
`default_nettype none
interface div_if;
	logic start;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic [31:0] quotient;
	logic [31:0] remainder;
	logic busy;
	modport ctl (output start, dividend, divisor, input quotient, remainder, busy);
	modport eng (input start, dividend, divisor, output quotient, remainder, busy);
endinterface
`default_nettype wire

// [src/udiv_engine.sv]
// Iterative unsigned 32-bit divider, one quotient bit per clock.
// Assumes start is only raised while busy is low.
`timescale 1ns/100ps
`default_nettype none
module udiv_engine
	import slice_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	div_if.eng dv
);
	typedef struct packed {
		logic busy;
		logic [5:0] cnt;
		logic [31:0] part;
		logic [31:0] quo;
		logic [31:0] dsr;
		logic [31:0] q_res;
		logic [31:0] r_res;
	} div_st_t;

	div_st_t q;
	div_st_t n;
	logic [32:0] shifted;
	logic [32:0] diff;

	// Restoring division; a zero divisor just runs out its steps, no trap.
	always_comb begin
		n = q;
		shifted = {q.part, q.quo[31]};
		diff = shifted - {1'b0, q.dsr};
		if (dv.start) begin
			n.busy = 1'b1;
			n.cnt = DIV_STEPS;
			n.part = '0;
			n.quo = dv.dividend;
			n.dsr = dv.divisor;
		end else if (q.busy) begin
			if (!diff[32]) begin
				n.part = diff[31:0];
			end else begin
				n.part = shifted[31:0];
			end
			n.quo = {q.quo[30:0], !diff[32]};
			n.cnt = q.cnt - 6'h01;
			if (q.cnt == 6'h01) begin
				n.busy = 1'b0;
				n.q_res = n.quo;
				n.r_res = n.part;
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign dv.busy = q.busy;
	assign dv.quotient = q.q_res;
	assign dv.remainder = q.r_res;
endmodule
`default_nettype wire

// [src/exec_slice.sv]
// Execution slice of the core: unsigned divide with its result registers,
// execution barrier, interrupt enable, exception return and bit field pull.
// Assumes the pipeline presents one instruction word with its two source
// values per cycle and holds it until issue_ready is seen high.
`timescale 1ns/100ps
`default_nettype none
module exec_slice
	import slice_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] src_rs,
	input wire logic [31:0] src_rt,
	input wire logic cp0_usable,
	input wire logic [2:0] arch_rev,
	input wire logic [1:0] isa_support_field,
	input wire logic compressed_impl,
	input wire logic hazard_pending,
	input wire logic [5:0] fpu_div_flags,
	input wire logic status_wr,
	input wire logic [31:0] status_wr_data,
	input wire logic [31:0] exc_return_pc,
	input wire logic [31:0] err_return_pc,
	input wire logic [3:0] previous_shadow_set,
	input wire logic [3:0] highest_shadow_set,
	input wire logic load_linked,
	output logic issue_ready,
	output logic gpr_wr,
	output logic [4:0] gpr_wr_idx,
	output logic [31:0] gpr_wr_data,
	output logic [31:0] quotient_reg,
	output logic [31:0] remainder_reg,
	output logic [31:0] status_reg,
	output logic [3:0] current_shadow_set,
	output logic compressed_isa_mode,
	output logic link_flag,
	output logic pc_redirect,
	output logic [31:0] pc_target,
	output logic clear_exec_hazard,
	output logic clear_instr_hazard,
	output logic solo_issue,
	output logic cop_unusable,
	output logic reserved_instr,
	output logic fp_raise,
	output logic [5:0] fp_flags
);
	typedef struct packed {
		state_t st;
		pend_t pend;
		logic [4:0] pidx;
		logic [31:0] pa;
		logic [31:0] pb;
		logic rdy;
		logic wr;
		logic [4:0] widx;
		logic [31:0] wdata;
		logic [31:0] status;
		logic [3:0] css;
		logic isa;
		logic llf;
		logic redir;
		logic [31:0] tgt;
		logic clr_ex;
		logic clr_in;
		logic solo;
		logic cpu_exc;
		logic ri;
		logic fpr;
		logic [5:0] fpf;
	} slice_st_t;

	localparam slice_st_t RST_ST = '{
		st: ST_RUN,
		pend: PEND_NONE,
		rdy: 1'b1,
		status: STATUS_RST,
		default: '0
	};

	div_if dv ();

	slice_st_t q;
	slice_st_t n;
	logic take;
	logic [5:0] opc;
	logic [5:0] fn;
	logic [4:0] rs_f;
	logic [4:0] rt_f;
	logic [4:0] rd_f;
	logic [4:0] msbd;
	logic [4:0] lsb;
	logic [31:0] ret_pc;
	logic [31:0] field_mask;
	logic dv_start;
	logic [31:0] dv_a;
	logic [31:0] dv_b;

	// Divide engine; its result registers are the quotient and remainder.
	udiv_engine u_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.dv(dv.eng)
	);

	assign dv.start = dv_start;
	assign dv.dividend = dv_a;
	assign dv.divisor = dv_b;

	// Instruction field split.
	assign take = issue_valid & q.rdy;
	assign opc = issue_instr[OP_HI:OP_LO];
	assign fn = issue_instr[FN_HI:FN_LO];
	assign rs_f = issue_instr[RS_HI:RS_LO];
	assign rt_f = issue_instr[RT_HI:RT_LO];
	assign rd_f = issue_instr[RD_HI:RD_LO];
	assign msbd = issue_instr[RD_HI:RD_LO];
	assign lsb = issue_instr[SA_HI:SA_LO];
	assign field_mask = 32'hFFFFFFFF >> (5'h1F - msbd);

	// Return address chosen by the error level.
	assign ret_pc = q.status[SB_ERL] ? err_return_pc : exc_return_pc;

	// Next-state logic of the whole slice.
	always_comb begin
		n = q;
		n.wr = 1'b0;
		n.redir = 1'b0;
		n.clr_ex = 1'b0;
		n.clr_in = 1'b0;
		n.solo = 1'b0;
		n.cpu_exc = 1'b0;
		n.ri = 1'b0;
		n.fpr = 1'b0;
		dv_start = 1'b0;
		dv_a = src_rs;
		dv_b = src_rt;
		if (status_wr) begin
			n.status = status_wr_data;
		end
		unique case (q.st)
			ST_RUN: begin
				if (take) begin
					if (issue_instr == BARRIER_WORD) begin
						// Stop issue; only execution hazards are waited on.
						n.st = ST_HOLD;
						n.rdy = 1'b0;
						n.solo = 1'b1;
					end else if (opc == OPC_SPECIAL && fn == FN_DIVIDE_U) begin
						// No exception path exists for any operand pair.
						if (dv.busy) begin
							n.st = ST_DIVW;
							n.rdy = 1'b0;
							n.pend = PEND_DIV;
							n.pa = src_rs;
							n.pb = src_rt;
						end else begin
							dv_start = 1'b1;
						end
					end else if (opc == OPC_SPECIAL && fn == FN_MOVE_REM) begin
						if (dv.busy) begin
							n.st = ST_DIVW;
							n.rdy = 1'b0;
							n.pend = PEND_REM;
							n.pidx = rd_f;
						end else begin
							n.wr = (rd_f != 5'h00);
							n.widx = rd_f;
							n.wdata = dv.remainder;
						end
					end else if (opc == OPC_SPECIAL && fn == FN_MOVE_QUOT) begin
						if (dv.busy) begin
							n.st = ST_DIVW;
							n.rdy = 1'b0;
							n.pend = PEND_QUOT;
							n.pidx = rd_f;
						end else begin
							n.wr = (rd_f != 5'h00);
							n.widx = rd_f;
							n.wdata = dv.quotient;
						end
					end else if (opc == OPC_COP0 && !issue_instr[CO_BIT]
						&& rs_f == RS_MISC_CP0 && issue_instr[SC_BIT]) begin
						if (arch_rev < REV_TWO) begin
							n.ri = 1'b1;
						end else if (!cp0_usable) begin
							n.cpu_exc = 1'b1;
						end else begin
							// Old status out and enable set in the same edge.
							n.wr = (rt_f != 5'h00);
							n.widx = rt_f;
							n.wdata = q.status;
							n.status[SB_IE] = 1'b1;
						end
					end else if (opc == OPC_COP0 && issue_instr[CO_BIT]
						&& fn == FN_EXC_RETURN) begin
						if (!cp0_usable) begin
							n.cpu_exc = 1'b1;
						end else begin
							if (q.status[SB_ERL]) begin
								n.status[SB_ERL] = 1'b0;
							end else begin
								n.status[SB_EXL] = 1'b0;
								if (arch_rev >= REV_TWO && highest_shadow_set != 4'h0
									&& !q.status[SB_BEV]) begin
									n.css = previous_shadow_set;
								end
							end
							if (compressed_impl || isa_support_field != 2'h0) begin
								n.tgt = {ret_pc[31:1], 1'b0};
								n.isa = ret_pc[0];
							end else begin
								n.tgt = ret_pc;
							end
							// Redirect on the next cycle; issue_ready stays high, so a following word can still be taken.
							n.redir = 1'b1;
							n.clr_ex = 1'b1;
							n.clr_in = 1'b1;
							n.llf = 1'b0;
						end
					end else if (opc == OPC_SPECIAL3 && fn == FN_PULL) begin
						if (arch_rev < REV_TWO) begin
							n.ri = 1'b1;
						end else begin
							n.wr = (rt_f != 5'h00);
							n.widx = rt_f;
							n.wdata = (src_rs >> lsb) & field_mask;
						end
					end else if (opc == OPC_COP1 && fn == FN_FP_DIV) begin
						// Capture the divider's condition flags for the FPU.
						n.fpr = 1'b1;
						n.fpf = fpu_div_flags;
					end
				end
			end
			ST_HOLD: begin
				// Resume once the pipeline reports no execution hazard.
				if (!hazard_pending) begin
					n.st = ST_RUN;
					n.rdy = 1'b1;
					n.clr_ex = 1'b1;
				end
			end
			ST_DIVW: begin
				// Interlock: finish the parked operation once the divider idles.
				if (!dv.busy) begin
					n.st = ST_RUN;
					n.rdy = 1'b1;
					n.pend = PEND_NONE;
					if (q.pend == PEND_DIV) begin
						dv_start = 1'b1;
						dv_a = q.pa;
						dv_b = q.pb;
					end else begin
						n.wr = (q.pidx != 5'h00);
						n.widx = q.pidx;
						if (q.pend == PEND_REM) begin
							n.wdata = dv.remainder;
						end else begin
							n.wdata = dv.quotient;
						end
					end
				end
			end
		endcase
		// A new linked load wins over a clear in the same cycle.
		if (load_linked) begin
			n.llf = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q <= RST_ST;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state register; quotient_reg and remainder_reg straight from the divider's result registers.
	assign issue_ready = q.rdy;
	assign gpr_wr = q.wr;
	assign gpr_wr_idx = q.widx;
	assign gpr_wr_data = q.wdata;
	assign quotient_reg = dv.quotient;
	assign remainder_reg = dv.remainder;
	assign status_reg = q.status;
	assign current_shadow_set = q.css;
	assign compressed_isa_mode = q.isa;
	assign link_flag = q.llf;
	assign pc_redirect = q.redir;
	assign pc_target = q.tgt;
	assign clear_exec_hazard = q.clr_ex;
	assign clear_instr_hazard = q.clr_in;
	assign solo_issue = q.solo;
	assign cop_unusable = q.cpu_exc;
	assign reserved_instr = q.ri;
	assign fp_raise = q.fpr;
	assign fp_flags = q.fpf;
endmodule
`default_nettype wire

// [testbench/exec_slice_asserts.sv]
// Concurrent checks on the execution slice ports.
// Assumes one clock, sys_clk, with synchronous active-low rst_b.
`timescale 1ns/100ps
`default_nettype none
module exec_slice_asserts
	import slice_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic cp0_usable,
	input wire logic [2:0] arch_rev,
	input wire logic [1:0] isa_support_field,
	input wire logic compressed_impl,
	input wire logic hazard_pending,
	input wire logic [5:0] fpu_div_flags,
	input wire logic [31:0] exc_return_pc,
	input wire logic [31:0] err_return_pc,
	input wire logic load_linked,
	input wire logic issue_ready,
	input wire logic gpr_wr,
	input wire logic [31:0] gpr_wr_data,
	input wire logic [31:0] status_reg,
	input wire logic compressed_isa_mode,
	input wire logic link_flag,
	input wire logic pc_redirect,
	input wire logic [31:0] pc_target,
	input wire logic clear_exec_hazard,
	input wire logic clear_instr_hazard,
	input wire logic solo_issue,
	input wire logic cop_unusable,
	input wire logic reserved_instr,
	input wire logic fp_raise,
	input wire logic [5:0] fp_flags
);
	logic tk, dv_t, ei_t, rt_t, px_t, fp_t, error_level_flag, rt_nz, cmp;
	logic [5:0] op, fn;
	logic [31:0] rpc;
	// Decoded takes, so each check keys on the word actually accepted.
	assign tk = issue_valid && issue_ready;
	assign op = issue_instr[31:26];
	assign fn = issue_instr[5:0];
	assign dv_t = tk && op == OPC_SPECIAL && fn == FN_DIVIDE_U;
	assign ei_t = tk && op == OPC_COP0 && issue_instr[25:21] == RS_MISC_CP0
		&& issue_instr[SC_BIT];
	assign rt_t = tk && op == OPC_COP0 && issue_instr[CO_BIT] && fn == FN_EXC_RETURN;
	assign px_t = tk && op == OPC_SPECIAL3 && fn == FN_PULL;
	assign fp_t = tk && op == OPC_COP1 && fn == FN_FP_DIV;
	assign error_level_flag = status_reg[SB_ERL];
	assign rt_nz = issue_instr[20:16] != 5'h00;
	assign cmp = compressed_impl || isa_support_field != 2'h0;
	assign rpc = error_level_flag ? err_return_pc : exc_return_pc;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	chk_barrier_stall: assert property (tk && issue_instr == BARRIER_WORD |=>
		solo_issue && !issue_ready)
		else $error("barrier did not stall issue");
	chk_barrier_wait: assert property (clear_exec_hazard && !clear_instr_hazard |->
		!$past(hazard_pending))
		else $error("barrier released while hazard pending");
	chk_div_quiet: assert property (dv_t |=>
		!cop_unusable && !reserved_instr && !fp_raise)
		else $error("divide raised an exception");
	chk_ei_copy: assert property (ei_t && cp0_usable && arch_rev >= REV_TWO |=>
		status_reg[SB_IE] && gpr_wr == $past(rt_nz)
		&& (!gpr_wr || gpr_wr_data == $past(status_reg)))
		else $error("interrupt enable result wrong");
	chk_ei_trap: assert property (ei_t && !cp0_usable && arch_rev >= REV_TWO |=>
		cop_unusable && !gpr_wr && $stable(status_reg))
		else $error("interrupt enable trap wrong");
	chk_ret_target: assert property (rt_t && cp0_usable |=>
		pc_redirect && clear_exec_hazard && clear_instr_hazard
		&& pc_target == ($past(rpc) & ~{31'h00000000, $past(cmp)}))
		else $error("return target wrong");
	chk_ret_flags: assert property (rt_t && cp0_usable && !load_linked |=>
		!link_flag && ($past(error_level_flag) ? !status_reg[SB_ERL] : !status_reg[SB_EXL]))
		else $error("return flags wrong");
	chk_ret_isa: assert property (rt_t && cp0_usable && cmp |=>
		!pc_target[0] && compressed_isa_mode == $past(rpc[0]))
		else $error("return mode wrong");
	chk_pull_rsvd: assert property (px_t && arch_rev < REV_TWO |=>
		reserved_instr && !gpr_wr)
		else $error("old revision pull not reserved");
	chk_fp_flags: assert property (fp_t |=>
		fp_raise && fp_flags == $past(fpu_div_flags))
		else $error("divide flags not captured");

	// Main scenarios seen at least once.
	cover property (tk && issue_instr == BARRIER_WORD);
	cover property (dv_t);
	cover property (rt_t && cp0_usable);
	cover property (ei_t && cp0_usable);
endmodule
bind exec_slice exec_slice_asserts exec_slice_asserts_inst (.*);
`default_nettype wire

// [testbench/exec_slice_tb_top.sv]
// Self-checking bench for the execution slice, random values plus corners.
// Assumes the checker is bound in; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module exec_slice_tb_top
	import slice_pkg::*;
;
	logic sys_clk = 1'b0, rst_b = 1'b0, issue_valid = 1'b0, cp0_usable = 1'b1;
	logic compressed_impl = 1'b0, hazard_pending = 1'b0, status_wr = 1'b0, load_linked = 1'b0;
	logic [31:0] issue_instr = 32'h0, src_rs = 32'h0, src_rt = 32'h0, status_wr_data = 32'h0;
	logic [31:0] exc_return_pc = 32'h0, err_return_pc = 32'h0;
	logic [2:0] arch_rev = 3'h2;
	logic [1:0] isa_support_field = 2'h0;
	logic [5:0] fpu_div_flags = 6'h00;
	logic [3:0] previous_shadow_set = 4'h0, highest_shadow_set = 4'h0, css_exp = 4'h0;
	logic issue_ready, gpr_wr, compressed_isa_mode, link_flag, pc_redirect, clear_exec_hazard;
	logic clear_instr_hazard, solo_issue, cop_unusable, reserved_instr, fp_raise, mode_exp;
	logic [4:0] gpr_wr_idx, r, p, m;
	logic [31:0] gpr_wr_data, quotient_reg, remainder_reg, status_reg, pc_target, a, b, st, t;
	logic [3:0] current_shadow_set;
	logic [5:0] fp_flags;
	integer seed = 99;
	int miscompares = 0, total_checks = 0, i;

	exec_slice exec_slice_inst (.*);

	// Free-running 100 MHz clock.
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// Reports the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Holds one word until taken; returns at the falling edge after the take.
	task automatic issue(input logic [31:0] w, input logic [31:0] x, input logic [31:0] y);
		int n;
		@(negedge sys_clk);
		issue_valid = 1'b1;
		issue_instr = w;
		src_rs = x;
		src_rt = y;
		for (n = 0; n < 200 && issue_ready !== 1'b1; n++) begin
			@(negedge sys_clk);
		end
		if (n == 200) begin
			miscompares++;
			complete_run();
		end
		@(negedge sys_clk);
		issue_valid = 1'b0;
	endtask

	// Waits, bounded, for a register write pulse.
	task automatic wait_gpr();
		int n;
		for (n = 0; n < 100 && gpr_wr !== 1'b1; n++) begin
			@(negedge sys_clk);
		end
		if (n == 100) begin
			miscompares++;
			complete_run();
		end
	endtask

	// Expected field pull: msbd plus one bits from base bit pos.
	function automatic logic [31:0] pull_exp(input logic [31:0] v, input logic [4:0] pos,
		input logic [4:0] msbd);
		logic [32:0] k;
		k = (33'h1 << (6'(msbd) + 6'h01)) - 33'h1;
		return (v >> pos) & k[31:0];
	endfunction

	// Expected return target for a given status.
	function automatic logic [31:0] ret_pc(input logic [31:0] s, input logic c);
		logic [31:0] q;
		q = s[SB_ERL] ? err_return_pc : exc_return_pc;
		return c ? (q & 32'hFFFFFFFE) : q;
	endfunction

	// Main sequence of tests.
	initial begin
		mode_exp = 1'b0;
		repeat (16) @(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		check(status_reg, STATUS_RST);
		check({31'h0, issue_ready}, 32'h1);
		for (i = 0; i < 8; i++) begin
			a = (i == 0) ? 32'hFFFFFFFF : $random(seed);
			b = (i == 0) ? 32'h2 : (i == 1) ? 32'h1 : ($random(seed) >> (i * 3)) | 32'h1;
			r = 5'(i + 1);
			issue({OPC_SPECIAL, 5'h01, 5'h02, 10'h000, FN_DIVIDE_U}, a, 32'h0);
			check({29'h0, reserved_instr, cop_unusable, fp_raise}, 32'h0);
			issue({OPC_SPECIAL, 5'h01, 5'h02, 10'h000, FN_DIVIDE_U}, a, b);
			issue({OPC_SPECIAL, 10'h000, r, 5'h00, FN_MOVE_QUOT}, 32'h0, 32'h0);
			wait_gpr();
			check(gpr_wr_data, a / b);
			check({27'h0, gpr_wr_idx}, {27'h0, r});
			issue({OPC_SPECIAL, 10'h000, r, 5'h00, FN_MOVE_REM}, 32'h0, 32'h0);
			wait_gpr();
			check(gpr_wr_data, a % b);
			check(quotient_reg, a / b);
			check(remainder_reg, a % b);
		end
		$display("divide test done");
		hazard_pending = 1'b1;
		issue(32'h00000080, 32'h0, 32'h0);
		check({31'h0, solo_issue}, 32'h0);
		issue(BARRIER_WORD, 32'h0, 32'h0);
		check({30'h0, solo_issue, issue_ready}, 32'h2);
		repeat (4) @(negedge sys_clk);
		check({31'h0, issue_ready}, 32'h0);
		hazard_pending = 1'b0;
		@(negedge sys_clk);
		check({29'h0, issue_ready, clear_exec_hazard, clear_instr_hazard}, 32'h6);
		$display("barrier test done");
		issue({OPC_COP0, RS_MISC_CP0, 5'h05, 16'h6020}, 32'h0, 32'h0);
		check({26'h0, gpr_wr, gpr_wr_idx}, 32'h25);
		check(gpr_wr_data, STATUS_RST);
		check(status_reg, STATUS_RST | 32'h1);
		issue({OPC_COP0, RS_MISC_CP0, 5'h00, 16'h6020}, 32'h0, 32'h0);
		check({31'h0, gpr_wr}, 32'h0);
		cp0_usable = 1'b0;
		issue({OPC_COP0, RS_MISC_CP0, 5'h03, 16'h6020}, 32'h0, 32'h0);
		check({30'h0, cop_unusable, gpr_wr}, 32'h2);
		check(status_reg, STATUS_RST | 32'h1);
		issue({OPC_COP0, 1'b1, 19'h0, FN_EXC_RETURN}, 32'h0, 32'h0);
		check({30'h0, cop_unusable, pc_redirect}, 32'h2);
		cp0_usable = 1'b1;
		arch_rev = 3'h1;
		issue({OPC_COP0, RS_MISC_CP0, 5'h03, 16'h6020}, 32'h0, 32'h0);
		check({30'h0, reserved_instr, gpr_wr}, 32'h2);
		arch_rev = 3'h2;
		// Software passes a barrier before it relies on the new enable state.
		issue(BARRIER_WORD, 32'h0, 32'h0);
		check(status_reg, STATUS_RST | 32'h1);
		$display("interrupt enable test done");
		for (i = 0; i < 8; i++) begin
			st = (i == 0) ? 32'h4 : (i == 1) ? 32'h2 : $random(seed) & 32'h00400006;
			arch_rev = (i == 7) ? 3'h1 : 3'h2;
			highest_shadow_set = (i == 1) ? 4'h3 : 4'($random(seed));
			previous_shadow_set = 4'($random(seed));
			compressed_impl = i[1];
			isa_support_field = {i[2], 1'b0};
			exc_return_pc = $random(seed);
			err_return_pc = $random(seed);
			load_linked = 1'b1;
			status_wr = 1'b1;
			status_wr_data = st;
			@(negedge sys_clk);
			load_linked = 1'b0;
			status_wr = 1'b0;
			check({31'h0, link_flag}, 32'h1);
			t = ret_pc(st, i[1] | i[2]);
			if (i[1] | i[2]) begin
				mode_exp = st[SB_ERL] ? err_return_pc[0] : exc_return_pc[0];
			end
			if (!st[SB_ERL] && arch_rev >= REV_TWO && highest_shadow_set != 4'h0 && !st[SB_BEV]) begin
				css_exp = previous_shadow_set;
			end
			issue({OPC_COP0, 1'b1, 19'h0, FN_EXC_RETURN}, 32'h0, 32'h0);
			check({29'h0, pc_redirect, clear_instr_hazard, link_flag}, 32'h6);
			check(pc_target, t);
			check(status_reg, st & (st[SB_ERL] ? 32'hFFFFFFFB : 32'hFFFFFFFD));
			check({27'h0, compressed_isa_mode, current_shadow_set}, {27'h0, mode_exp, css_exp});
		end
		$display("return test done");
		arch_rev = 3'h2;
		for (i = 0; i < 9; i++) begin
			a = $random(seed);
			p = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
			m = (i == 0) ? 5'h1F : 5'(($random(seed) & 32'h1F) % (32 - p));
			r = 5'(i + 1);
			arch_rev = (i == 8) ? 3'h1 : 3'h2;
			issue({OPC_SPECIAL3, 5'h03, r, m, p, FN_PULL}, a, 32'h0);
			if (i == 8) begin
				check({30'h0, reserved_instr, gpr_wr}, 32'h2);
			end else begin
				check(gpr_wr_data, pull_exp(a, p, m));
				check({27'h0, gpr_wr_idx}, {27'h0, r});
			end
		end
		$display("bit pull test done");
		for (i = 0; i < 7; i++) begin
			fpu_div_flags = (i < 6) ? 6'h01 << i : 6'($random(seed));
			issue({OPC_COP1, 20'h0, FN_FP_DIV}, 32'h0, 32'h0);
			check({25'h0, fp_raise, fp_flags}, {25'h0, 1'b1, fpu_div_flags});
		end
		$display("float flags test done");
		complete_run();
	end
endmodule
`default_nettype wire
